// >>> bench/fta_ctrl_model.sv
// controller model: offers operands and collects the written string
`timescale 1ns/1ps
module fta_ctrl_model
  import fta_pkg::*;
(
  // clock and block status
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic done,
  input wire logic str_wr_en,
  input wire fta_word_t str_wr,
  // request
  output logic exec_en,
  output logic pulsed_mode,
  output logic [31:0] source_value,
  output fta_fmt_t format_spec,
  output logic [15:0] dest_words_avail
);
  logic [15:0] words [0:15];
  int nwords;
  // store every word the block writes; the falling edge keeps clear of
  // the rising edge that launches the write strobe
  always @(negedge clk_sys) begin
    if (str_wr_en) begin
      words[str_wr.addr[3:0]] = str_wr.data;
      nwords++;
    end
  end
  // idle drive at time zero
  initial begin
    exec_en = 1'b0;
    pulsed_mode = 1'b0;
    source_value = 32'h0;
    format_spec = '0;
    dest_words_avail = 16'h0;
  end
  // one conversion; operands are scrambled once taken, as a real scan would
  task automatic run(input logic pm, input logic [31:0] v,
                     input fta_fmt_t f, input logic [15:0] av);
    int n;
    @(posedge clk_sys);
    #1;
    nwords = 0;
    pulsed_mode = pm;
    source_value = v;
    format_spec = f;
    dest_words_avail = av;
    exec_en = 1'b1;
    for (n = 0; n < 4 && !busy; n++) begin
      @(posedge clk_sys);
      #1;
    end
    exec_en = 1'b0;
    source_value = ~v;
    format_spec = ~f;
    dest_words_avail = ~av;
    for (n = 0; n < 6000 && !done; n++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
endmodule

// >>> bench/fta_formatter_bench.sv
// self-checking bench for the float to ascii formatter
`timescale 1ns/1ps
module fta_formatter_bench
  import fta_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic exec_en, pulsed_mode, str_wr_en, busy, done, operation_error_flag;
  logic [31:0] source_value;
  logic [15:0] dest_words_avail, error_code_word;
  fta_fmt_t format_spec;
  fta_word_t str_wr;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  fta_formatter dut (.clk_sys(clk_sys), .resetn(resetn), .exec_en(exec_en),
    .pulsed_mode(pulsed_mode), .source_value(source_value),
    .format_spec(format_spec), .dest_words_avail(dest_words_avail),
    .str_wr_en(str_wr_en), .str_wr(str_wr), .busy(busy), .done(done),
    .operation_error_flag(operation_error_flag),
    .error_code_word(error_code_word));

  fta_ctrl_model m (.clk_sys(clk_sys), .busy(busy), .done(done),
    .str_wr_en(str_wr_en), .str_wr(str_wr), .exec_en(exec_en),
    .pulsed_mode(pulsed_mode), .source_value(source_value),
    .format_spec(format_spec), .dest_words_avail(dest_words_avail));

  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic fta_fmt_t mk(input logic [15:0] n, t, f);
    return {n, t, f};
  endfunction

  // expected words built from the text, terminator padded with zeros
  task automatic check_str(input string s, input int total);
    logic [7:0] lo, hi;
    int w;
    chk_bit("error flag", 1'b0, operation_error_flag);
    chk_bit("busy after done", 1'b0, busy);
    chk16("word count", 16'(total / 2 + 1), m.nwords[15:0]);
    for (w = 0; w <= total / 2; w++) begin
      lo = 2 * w < s.len() ? s[2 * w] : 8'h00;
      hi = 2 * w + 1 < s.len() ? s[2 * w + 1] : 8'h00;
      chk16("string word", {hi, lo}, m.words[w]);
    end
  endtask

  task automatic expect_err(input logic pm, input logic [31:0] v,
                            input fta_fmt_t f, input logic [15:0] av);
    m.run(pm, v, f, av);
    chk_bit("error flag", 1'b1, operation_error_flag);
    chk16("error code", 16'h1A32, error_code_word);
    chk16("words on error", 16'h0, m.nwords[15:0]);
  endtask

  // every refusal, both trigger forms, nothing written
  task automatic t_errors();
    chk16("code after reset", 16'h0000, error_code_word);
    expect_err(0, 32'h3FC00000, mk(16'h2, 16'h5, 16'h1), 16'h3);
    expect_err(1, 32'h3FC00000, mk(16'h0, 16'h1, 16'h0), 16'h3);
    expect_err(0, 32'h3FC00000, mk(16'h1, 16'h5, 16'h0), 16'h8);
    expect_err(0, 32'h3FC00000, mk(16'h0, 16'h5, 16'h3), 16'h3);
    expect_err(1, 32'h3FC00000, mk(16'h1, 16'h9, 16'h3), 16'h8);
    expect_err(0, 32'h7F800000, mk(16'h0, 16'h5, 16'h1), 16'h3);
    expect_err(0, 32'h00000001, mk(16'h0, 16'h5, 16'h1), 16'h3);
    expect_err(0, 32'h3FC00000, mk(16'h0, 16'h5, 16'h1), 16'h2);
    expect_err(0, 32'h3FC00000, mk(16'h0, 16'hC, 16'h8), 16'h7);
    expect_err(1, 32'h3FC00000, mk(16'h1, 16'h19, 16'h0), 16'hD);
    expect_err(0, 32'h42F60000, mk(16'h0, 16'h3, 16'h0), 16'h2);
  endtask

  task automatic t_dec();
    m.run(1, 32'h3FC00000, mk(16'h0, 16'h5, 16'h1), 16'h3);
    check_str("  1.5", 5);
  endtask

  task automatic t_round();
    m.run(0, 32'hC0300000, mk(16'h0, 16'h4, 16'h1), 16'h3);
    check_str("-2.8", 4);
  endtask

  task automatic t_nopoint();
    m.run(0, 32'h40400000, mk(16'h0, 16'h3, 16'h0), 16'h2);
    check_str("  3", 3);
  endtask

  // zero is accepted and prints as zero digits
  task automatic t_zero();
    m.run(1, 32'h00000000, mk(16'h0, 16'h4, 16'h1), 16'h3);
    check_str(" 0.0", 4);
  endtask

  task automatic t_exp();
    m.run(0, 32'h41480000, mk(16'h1, 16'h9, 16'h2), 16'h5);
    check_str(" 1.25E+01", 9);
  endtask

  task automatic t_exp_neg();
    m.run(1, 32'h3D800000, mk(16'h1, 16'hA, 16'h1), 16'h6);
    check_str("   6.3E-02", 10);
  endtask

  // hang guard well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 50000) begin
      errors++;
      final_report();
    end
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    t_errors();
    t_dec();
    t_round();
    t_nopoint();
    t_zero();
    t_exp();
    t_exp_neg();
    final_report();
  end
endmodule

// >>> bench/fta_formatter_sva.sv
// assertion checker for the float to ascii formatter ports
`timescale 1ns/1ps
module fta_formatter_sva
  import fta_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // request
  input wire logic exec_en,
  input wire logic pulsed_mode,
  input wire logic [31:0] source_value,
  input wire fta_fmt_t format_spec,
  input wire logic [15:0] dest_words_avail,
  // results
  input wire logic str_wr_en,
  input wire fta_word_t str_wr,
  input wire logic busy,
  input wire logic done,
  input wire logic operation_error_flag,
  input wire logic [15:0] error_code_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // refusal checks watch continuous takes only: pulsed takes depend on edge memory
  wire start_c = !busy && exec_en && !pulsed_mode;
  wire [16:0] tot = {1'b0, format_spec.total};
  wire [16:0] frc = {1'b0, format_spec.frac};
  wire is_exp = format_spec.notation == 16'h0001;
  wire bad_min = frc == 17'h0 && tot < (is_exp ? 17'h6 : 17'h2);
  wire bad_frc = frc != 17'h0 && tot < frc + (is_exp ? 17'h7 : 17'h3);
  wire [7:0] ex = source_value[30:23];
  wire bad_val = ex == 8'hFF || (ex == 8'h00 && source_value[22:0] != 23'h0);
  wire bad_dst = {1'b0, dest_words_avail} < {1'b0, tot[16:1]} + 17'h1;
  logic sign_r;
  // sign of the value offered while idle, kept for the first word
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) sign_r <= 1'b0;
    else if (!busy && exec_en) sign_r <= source_value[31];
  end
  property p_code;
    $rose(operation_error_flag) |-> error_code_word == 16'h1A32 ##[0:2] done;
  endproperty
  a_code: assert property (p_code)
    else $error("error code or done wrong");
  property p_nowr;
    operation_error_flag |-> !str_wr_en;
  endproperty
  a_nowr: assert property (p_nowr) else $error("write after error");
  property p_type;
    start_c && format_spec.notation > 16'h0001 |->
      ##3 done && operation_error_flag;
  endproperty
  a_type: assert property (p_type) else $error("bad type accepted");
  property p_min;
    start_c && bad_min |-> ##3 done && operation_error_flag;
  endproperty
  a_min: assert property (p_min)
    else $error("short total accepted");
  property p_frc;
    start_c && bad_frc |-> ##3 done && operation_error_flag;
  endproperty
  a_frc: assert property (p_frc)
    else $error("fraction count accepted");
  property p_val;
    start_c && bad_val |-> ##3 done && operation_error_flag;
  endproperty
  a_val: assert property (p_val) else $error("bad value accepted");
  property p_dst;
    start_c && bad_dst |-> ##3 done && operation_error_flag;
  endproperty
  a_dst: assert property (p_dst) else $error("small area accepted");
  property p_sign;
    str_wr_en && str_wr.addr == 16'h0000 |->
      str_wr.data[7:0] == (sign_r ? 8'h2D : 8'h20);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign character wrong");
  property p_term;
    done && !operation_error_flag |-> str_wr.data[15:8] == 8'h00;
  endproperty
  a_term: assert property (p_term) else $error("no terminator");
endmodule

bind fta_formatter fta_formatter_sva u_sva (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .exec_en(exec_en),
  .pulsed_mode(pulsed_mode),
  .source_value(source_value),
  .format_spec(format_spec),
  .dest_words_avail(dest_words_avail),
  .str_wr_en(str_wr_en),
  .str_wr(str_wr),
  .busy(busy),
  .done(done),
  .operation_error_flag(operation_error_flag),
  .error_code_word(error_code_word)
);

// >>> hw/fta_defs.svh
// constants for the float to ascii formatter
`ifndef FTA_DEFS_SVH
`define FTA_DEFS_SVH
// ascii codes
`define FTA_CH_SPACE 8'h20
`define FTA_CH_MINUS 8'h2D
`define FTA_CH_PLUS 8'h2B
`define FTA_CH_POINT 8'h2E
`define FTA_CH_ZERO 8'h30
`define FTA_CH_EXP 8'h45
`define FTA_CH_NUL 8'h00
// error code 6706 decimal
`define FTA_ERR_CODE 16'h1A32
// notation type values
`define FTA_NOT_DEC 16'h0000
`define FTA_NOT_EXP 16'h0001
// format limits
`define FTA_DEC_MIN0 16'h0002
`define FTA_DEC_EXTRA 16'h0003
`define FTA_EXP_MIN0 16'h0006
`define FTA_EXP_EXTRA 16'h0007
`define FTA_EXP_TAIL 16'h0004
`define FTA_EXP_MAX_TOTAL 16'h0018
`define FTA_MAX_FRAC 16'h0007
// digit arithmetic
`define FTA_ROUND_DIGIT 4'h5
`define FTA_TEN 5'h0A
// fixed point layout: integer bits, fraction bits, full loaded width
`define FTA_IB 128
`define FTA_FB 149
`define FTA_W 277
// digit store: index of the 10^0 digit and number of entries
`define FTA_OFF 7'h30
`define FTA_ND 96
// single precision fields
`define FTA_EXP_MAX 8'hFF
`define FTA_INT_LAST 7'h7F
`endif

// >>> hw/fta_formatter.sv
// float to ascii formatter: single precision value to packed text string
`timescale 1ns/1ps
`include "fta_defs.svh"

module fta_formatter
  import fta_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // execution request
  input wire logic exec_en,
  input wire logic pulsed_mode,
  input wire logic [31:0] source_value,
  input wire fta_fmt_t format_spec,
  input wire logic [15:0] dest_words_avail,
  // string word writes
  output logic str_wr_en,
  output fta_word_t str_wr,
  // status
  output logic busy,
  output logic done,
  output logic operation_error_flag,
  output logic [15:0] error_code_word
);

  fta_state_t state_r;
  logic en_prev_r;
  logic [31:0] val_r;
  fta_fmt_t fmt_r;
  logic [15:0] avail_r;
  logic [3:0] dg_r [0:`FTA_ND-1];
  logic [`FTA_IB-1:0] ip_r;
  logic [`FTA_FB-1:0] fp_r;
  logic [3:0] rem_r;
  logic [6:0] bit_cnt_r;
  logic [6:0] idx_r;
  logic [6:0] top_r;
  logic have_top_r;
  logic [15:0] chr_r;
  logic [15:0] word_r;
  logic wr_en_r;
  fta_word_t wr_r;
  logic done_r;
  logic err_r;
  logic [15:0] code_r;
  // request: continuous form runs while enabled, pulsed form on a rise
  wire start = (state_r == ST_IDLE) && exec_en &&
               (!pulsed_mode || !en_prev_r);
  // format decode
  wire is_exp = (fmt_r.notation == `FTA_NOT_EXP);
  wire bad_type = (fmt_r.notation != `FTA_NOT_DEC) && !is_exp;
  wire fz = (fmt_r.frac == 16'h0000);
  wire [6:0] frac7 = fmt_r.frac[6:0];
  wire [15:0] extra = is_exp ? `FTA_EXP_EXTRA : `FTA_DEC_EXTRA;
  wire [15:0] min0 = is_exp ? `FTA_EXP_MIN0 : `FTA_DEC_MIN0;
  wire [15:0] need_min = fz ? min0 : fmt_r.frac + extra;
  wire bad_total = (fmt_r.total < need_min) ||
                   (is_exp && fmt_r.total > `FTA_EXP_MAX_TOTAL);
  wire bad_frac = (fmt_r.frac > `FTA_MAX_FRAC) ||
                  (!fz && fmt_r.frac > fmt_r.total - extra);
  // value range: zero or a normal finite number only
  wire [7:0] ef = val_r[30:23];
  wire [22:0] mf = val_r[22:0];
  wire is_zero = (ef == 8'h00) && (mf == 23'h000000);
  wire bad_val = ((ef == 8'h00) && !is_zero) ||
                 (ef == `FTA_EXP_MAX);
  // destination size: one word more than half the total, rounded down
  wire [15:0] words_need = {1'b0, fmt_r.total[15:1]} + 16'h0001;
  wire bad_dest = words_need > avail_r;
  wire fmt_err = bad_type || bad_total || bad_frac || bad_val || bad_dest;
  // exact fixed point image of the value, binary point above bit FB-1
  wire [`FTA_W-1:0] load_src = {253'h0, 1'b1, mf};
  wire [`FTA_W-1:0] load_w = load_src << (ef - 8'h01);
  // serial divide by ten of the integer part, one bit per cycle
  wire [4:0] rem_sh = {rem_r, ip_r[`FTA_IB-1]};
  wire rem_ge = rem_sh >= `FTA_TEN;
  wire [3:0] rem_new = rem_ge ? 4'(rem_sh - `FTA_TEN) : rem_sh[3:0];
  wire [`FTA_IB-1:0] quot = {ip_r[`FTA_IB-2:0], rem_ge};
  // fraction times ten: the carry out is the next digit
  wire [`FTA_FB+3:0] fprod = ({4'h0, fp_r} << 3) + ({4'h0, fp_r} << 1);
  wire [3:0] fdig = fprod[`FTA_FB+3:`FTA_FB];
  // lowest kept digit and the digit that decides rounding
  wire [6:0] keep_lo = is_exp ? top_r - frac7 : `FTA_OFF - frac7;
  wire [6:0] gen_lo = keep_lo - 7'h01;
  wire round_up = dg_r[gen_lo] >= `FTA_ROUND_DIGIT;
  wire frac_skip = is_exp && have_top_r && (idx_r < gen_lo);
  wire frac_last = (!is_exp || have_top_r) && (idx_r == gen_lo);
  wire [3:0] carry_sum = dg_r[idx_r] + 4'h1;
  // layout of the integer field in decimal notation
  wire [15:0] frac_len = fz ? 16'h0000 : fmt_r.frac + 16'h0001;
  wire [15:0] int_field = fmt_r.total - 16'h0001 - frac_len;
  wire [15:0] int_need = (have_top_r && top_r >= `FTA_OFF) ?
                         {9'h000, 7'(top_r - `FTA_OFF)} + 16'h0001 :
                         16'h0001;
  wire bad_fit = !is_exp && (int_need > int_field);
  // layout of the exponential form
  wire [15:0] exp_pad = fmt_r.total - `FTA_EXP_MIN0 - frac_len;
  wire [15:0] tail = fmt_r.total - `FTA_EXP_TAIL;
  wire exp_neg = top_r < `FTA_OFF;
  wire [6:0] exp_mag = exp_neg ? `FTA_OFF - top_r : top_r - `FTA_OFF;
  wire [6:0] exp_tens = exp_mag / 7'h0A;
  wire [6:0] exp_ones = exp_mag % 7'h0A;
  wire [7:0] sign_ch = val_r[31] ? `FTA_CH_MINUS : `FTA_CH_SPACE;
  // digit store entry as an ascii digit
  function automatic logic [7:0] dig_ch(input logic [6:0] ix);
    dig_ch = `FTA_CH_ZERO + {4'h0, dg_r[ix]};
  endfunction
  // character at string position c; positions past the end read as nul
  function automatic logic [7:0] char_at(input logic [15:0] c);
    logic [15:0] k;
    k = 16'h0000;
    if (c >= fmt_r.total) begin
      char_at = `FTA_CH_NUL;
    end else if (c == 16'h0000) begin
      char_at = sign_ch;
    end else if (!is_exp) begin
      if (c <= int_field) begin
        k = int_field - c;
        char_at = (k >= int_need) ? `FTA_CH_SPACE :
                  dig_ch(7'(`FTA_OFF + k[6:0]));
      end else if (c == int_field + 16'h0001) begin
        char_at = `FTA_CH_POINT;
      end else begin
        k = c - int_field - 16'h0001;
        char_at = dig_ch(7'(`FTA_OFF - k[6:0]));
      end
    end else if (c == tail) begin
      char_at = `FTA_CH_EXP;
    end else if (c == tail + 16'h0001) begin
      char_at = exp_neg ? `FTA_CH_MINUS : `FTA_CH_PLUS;
    end else if (c == tail + 16'h0002) begin
      char_at = `FTA_CH_ZERO + {1'b0, exp_tens};
    end else if (c == tail + 16'h0003) begin
      char_at = `FTA_CH_ZERO + {1'b0, exp_ones};
    end else if (c <= exp_pad) begin
      char_at = `FTA_CH_SPACE;
    end else if (c == exp_pad + 16'h0001) begin
      char_at = dig_ch(top_r);
    end else if (c == exp_pad + 16'h0002) begin
      char_at = `FTA_CH_POINT;
    end else begin
      k = c - exp_pad - 16'h0002;
      char_at = dig_ch(7'(top_r - k[6:0]));
    end
  endfunction
  // earlier character in the low byte
  wire [15:0] word_data = {char_at(chr_r + 16'h0001), char_at(chr_r)};
  wire emit_last = (chr_r + 16'h0001) >= fmt_r.total;
  // edge memory for the pulsed form
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= exec_en;
    end
  end
  // conversion sequencer; a pulsed request arriving while busy is dropped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      val_r <= 32'h00000000;
      fmt_r <= '0;
      avail_r <= 16'h0000;
      for (int i = 0; i < `FTA_ND; i++) begin
        dg_r[i] <= 4'h0;
      end
      ip_r <= '0;
      fp_r <= '0;
      rem_r <= 4'h0;
      bit_cnt_r <= 7'h00;
      idx_r <= 7'h00;
      top_r <= 7'h00;
      have_top_r <= 1'b0;
      chr_r <= 16'h0000;
      word_r <= 16'h0000;
      wr_en_r <= 1'b0;
      wr_r <= '0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      code_r <= 16'h0000;
    end else begin
      wr_en_r <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            val_r <= source_value;
            fmt_r <= format_spec;
            avail_r <= dest_words_avail;
            err_r <= 1'b0;
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (fmt_err) begin
            err_r <= 1'b1;
            code_r <= `FTA_ERR_CODE;
            state_r <= ST_DONE;
          end else begin
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          for (int i = 0; i < `FTA_ND; i++) begin
            dg_r[i] <= 4'h0;
          end
          ip_r <= load_w[`FTA_W-1:`FTA_FB];
          fp_r <= load_w[`FTA_FB-1:0];
          rem_r <= 4'h0;
          bit_cnt_r <= 7'h00;
          idx_r <= `FTA_OFF;
          top_r <= `FTA_OFF;
          // zero prints as all zero digits with exponent +00
          have_top_r <= is_zero;
          if (is_zero) begin
            state_r <= ST_FIT;
          end else if (load_w[`FTA_W-1:`FTA_FB] != '0) begin
            state_r <= ST_INT;
          end else begin
            idx_r <= `FTA_OFF - 7'h01;
            state_r <= ST_FRAC;
          end
        end
        ST_INT: begin
          ip_r <= quot;
          rem_r <= rem_new;
          bit_cnt_r <= bit_cnt_r + 7'h01;
          if (bit_cnt_r == `FTA_INT_LAST) begin
            dg_r[idx_r] <= rem_new;
            top_r <= idx_r;
            have_top_r <= 1'b1;
            rem_r <= 4'h0;
            idx_r <= idx_r + 7'h01;
            if (quot == '0) begin
              idx_r <= `FTA_OFF - 7'h01;
              state_r <= ST_FRAC;
            end
          end
        end
        ST_FRAC: begin
          if (frac_skip) begin
            state_r <= ST_ROUND;
          end else begin
            dg_r[idx_r] <= fdig;
            fp_r <= fprod[`FTA_FB-1:0];
            idx_r <= idx_r - 7'h01;
            // exponential form keys its digits to the first nonzero one
            if (is_exp && !have_top_r && fdig != 4'h0) begin
              top_r <= idx_r;
              have_top_r <= 1'b1;
            end
            if (frac_last) begin
              state_r <= ST_ROUND;
            end
          end
        end
        ST_ROUND: begin
          idx_r <= keep_lo;
          state_r <= round_up ? ST_CARRY : ST_FIT;
        end
        ST_CARRY: begin
          // a carry out of the top digit makes a new leading one
          if (carry_sum == 4'hA) begin
            dg_r[idx_r] <= 4'h0;
            idx_r <= idx_r + 7'h01;
          end else begin
            dg_r[idx_r] <= carry_sum;
            if (!have_top_r || idx_r > top_r) begin
              top_r <= idx_r;
              have_top_r <= 1'b1;
            end
            state_r <= ST_FIT;
          end
        end
        ST_FIT: begin
          chr_r <= 16'h0000;
          word_r <= 16'h0000;
          if (bad_fit) begin
            err_r <= 1'b1;
            code_r <= `FTA_ERR_CODE;
            state_r <= ST_DONE;
          end else begin
            state_r <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          wr_en_r <= 1'b1;
          wr_r.addr <= word_r;
          wr_r.data <= word_data;
          chr_r <= chr_r + 16'h0002;
          word_r <= word_r + 16'h0001;
          if (emit_last) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          done_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  // outputs
  assign busy = (state_r != ST_IDLE);
  assign done = done_r;
  assign str_wr_en = wr_en_r;
  assign str_wr = wr_r;
  assign operation_error_flag = err_r;
  assign error_code_word = code_r;
endmodule

// >>> hw/fta_pkg.sv
// types for the float to ascii formatter
package fta_pkg;
  typedef struct packed {
    logic [15:0] notation;
    logic [15:0] total;
    logic [15:0] frac;
  } fta_fmt_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } fta_word_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CHECK, ST_LOAD, ST_INT, ST_FRAC, ST_ROUND, ST_CARRY,
    ST_FIT, ST_EMIT, ST_DONE
  } fta_state_t;
endpackage
